/* design/temp_sensor_controller.v */
// Purpose: Digital controller for an on-chip temperature sensor comparator
// Assumes: Register port is synchronous to ref_clk_in; comparator input already synchronous
// Notes: Sweep, wait and sampling all advance on divided ticks
// What this block does
// - Level field drives sensor in raw mode, else serves as alarm threshold.
// - Controller advances at digital clock divided by the 8-bit divider.
// - Programmed number of wait cycles is inserted between measurements.
// - Result register bit 7 shows the comparator output directly.
// - Result bit 6 alarm sets when measured value exceeds threshold.
// - Result bits 5..0 hold the latest completed measurement.
// - Read-only peak-high register keeps largest value since its clear.
// - Read-only peak-low register keeps smallest value since its clear.
// - Mode field selects raw, one-shot, continuous, or continuous with held alarm.
// - Wide sweep bit chooses span 22..63 when clear, 0..63 when set.
// - Writing one to peak-high clear resets the maximum; zero does nothing.
// - Writing one to alarm clear resets the alarm flag; zero does nothing.
`timescale 1ns/10ps
`include "temp_sensor_defines.vh"
module temp_sensor_controller (
   input wire ref_clk_in, // 20 MHz digital clock
   input wire rst_n_in, // Synchronous reset, active low
   input wire [7:0] reg_addr_in, // Register address
   input wire [7:0] reg_wdata_in, // Write data
   input wire reg_wr_in, // Write strobe, one cycle
   input wire reg_rd_in, // Read strobe, one cycle
   output reg [7:0] reg_rdata_out, // Read data, valid cycle after strobe
   input wire sensor_cmp_in, // Comparator output from sensor
   output wire [5:0] sensor_level_out, // Level driven to sensor
   output wire sensor_pon_out, // Sensor power enable
   output wire busy_out // Measurement in progress
);
   localparam ST_IDLE = 3'b001;
   localparam ST_SWEEP = 3'b010;
   localparam ST_WAIT = 3'b100;

   reg [7:0] ctrl;
   reg [5:0] level_select_field;
   reg [7:0] divider;
   reg [7:0] wait_cycles;
   reg [5:0] result;
   reg alarm;
   reg [5:0] peak_high;
   reg [5:0] peak_low;
   reg [2:0] state;
   reg [5:0] sweep_level;
   reg [7:0] wait_count;
   reg first_step;
   reg prev_cmp;
   reg oneshot_req;
   reg done;
   reg [5:0] done_value;
   wire tick;
   wire [1:0] measure_mode_sig;
   wire wide_sweep_bit;
   wire wait_rise;
   wire ctrl_wr;
   wire clear_peak_high;
   wire clear_peak_low;
   wire clear_alarm;
   wire continuous;
   wire hit;
   wire [5:0] sweep_start;

   assign measure_mode_sig = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
   assign wide_sweep_bit = ctrl[`CTRL_WIDE_BIT];
   assign wait_rise = ~ctrl[`CTRL_TOGGLE_BIT];
   assign ctrl_wr = reg_wr_in && (reg_addr_in == `SNS_CTRL_ADDR);
   assign clear_peak_high = ctrl_wr && reg_wdata_in[`CTRL_CLR_HI_BIT];
   assign clear_peak_low = ctrl_wr && reg_wdata_in[`CTRL_CLR_LO_BIT];
   assign clear_alarm = ctrl_wr && reg_wdata_in[`CTRL_CLR_ALARM_BIT];
   assign continuous = measure_mode_sig[1];
   assign sweep_start = wide_sweep_bit ? `SWEEP_WIDE_START : `SWEEP_NARROW_START;
   // Awaited edge of comparator, direction from toggle bit
   assign hit = !first_step && (prev_cmp != sensor_cmp_in) && (sensor_cmp_in == wait_rise);

   // Sensor drive: raw level or sweep level
   assign sensor_level_out = (measure_mode_sig == `MODE_RAW) ? level_select_field : sweep_level;
   assign sensor_pon_out = ctrl[`CTRL_PON_BIT];
   assign busy_out = (state != ST_IDLE);

   // Divided tick generator
   sensor_clock_tick #(
      .WIDTH(8)
   ) u_tick (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .div_in(divider),
      .tick_out(tick)
   );

   // Writable registers; clear bits do not store
   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         ctrl <= `CTRL_RESET;
         level_select_field <= `LEVEL_RESET;
         divider <= `DIV_RESET;
         wait_cycles <= `WAIT_RESET;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            `SNS_CTRL_ADDR: begin
               ctrl <= reg_wdata_in & 8'hb3;
            end
            `SNS_LEVEL_ADDR: begin
               level_select_field <= reg_wdata_in[5:0];
            end
            `SNS_DIV_ADDR: begin
               divider <= reg_wdata_in;
            end
            `SNS_WAIT_ADDR: begin
               wait_cycles <= reg_wdata_in;
            end
            default: begin
               ctrl <= ctrl;
            end
         endcase
      end
   end

   // One-shot request armed by writing mode one-shot
   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         oneshot_req <= 1'b0;
      end else if (ctrl_wr && reg_wdata_in[`CTRL_MODE_HI:`CTRL_MODE_LO] == `MODE_ONESHOT) begin
         oneshot_req <= 1'b1;
      end else if (state == ST_SWEEP || !(measure_mode_sig == `MODE_ONESHOT)) begin
         oneshot_req <= 1'b0;
      end
   end

   // Measurement sequencer on divided ticks
   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         state <= ST_IDLE;
         sweep_level <= `SWEEP_NARROW_START;
         wait_count <= 8'h00;
         first_step <= 1'b1;
         prev_cmp <= 1'b0;
         done <= 1'b0;
         done_value <= 6'h00;
      end else begin
         done <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (sensor_pon_out && (continuous || oneshot_req)) begin
                  state <= ST_SWEEP;
                  sweep_level <= sweep_start;
                  first_step <= 1'b1;
               end
            end
            ST_SWEEP: begin
               if (measure_mode_sig == `MODE_RAW || !sensor_pon_out) begin
                  state <= ST_IDLE;
               end else if (tick) begin
                  prev_cmp <= sensor_cmp_in;
                  first_step <= 1'b0;
                  if (hit || sweep_level == `SWEEP_END) begin
                     done <= 1'b1;
                     done_value <= sweep_level;
                     wait_count <= 8'h00;
                     state <= continuous ? ST_WAIT : ST_IDLE;
                  end else begin
                     sweep_level <= sweep_level + 6'h01;
                  end
               end
            end
            ST_WAIT: begin
               if (!continuous || !sensor_pon_out) begin
                  state <= ST_IDLE;
               end else if (wait_count >= wait_cycles) begin
                  state <= ST_SWEEP;
                  sweep_level <= sweep_start;
                  first_step <= 1'b1;
               end else if (tick) begin
                  wait_count <= wait_count + 8'h01;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Result, alarm and peak tracking; new value wins over clear
   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         result <= 6'h00;
         alarm <= 1'b0;
         peak_high <= `PEAK_HI_RESET;
         peak_low <= `PEAK_LO_RESET;
      end else begin
         if (done) begin
            result <= done_value;
         end
         if (done && done_value > level_select_field) begin
            alarm <= 1'b1;
         end else if (done && measure_mode_sig != `MODE_CONT_HOLD) begin
            alarm <= 1'b0;
         end else if (clear_alarm) begin
            alarm <= 1'b0;
         end
         if (done && (clear_peak_high || done_value > peak_high)) begin
            peak_high <= done_value;
         end else if (clear_peak_high) begin
            peak_high <= `PEAK_HI_RESET;
         end
         if (done && (clear_peak_low || done_value < peak_low)) begin
            peak_low <= done_value;
         end else if (clear_peak_low) begin
            peak_low <= `PEAK_LO_RESET;
         end
      end
   end

   // Registered read data; unmapped reads return zero
   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `SNS_CTRL_ADDR: reg_rdata_out <= ctrl;
            `SNS_LEVEL_ADDR: reg_rdata_out <= {2'b00, level_select_field};
            `SNS_DIV_ADDR: reg_rdata_out <= divider;
            `SNS_WAIT_ADDR: reg_rdata_out <= wait_cycles;
            `SNS_RESULT_ADDR: reg_rdata_out <= {sensor_cmp_in, alarm, result};
            `SNS_PEAK_HI_ADDR: reg_rdata_out <= {2'b00, peak_high};
            `SNS_PEAK_LO_ADDR: reg_rdata_out <= {2'b00, peak_low};
            default: reg_rdata_out <= 8'h00;
         endcase
      end
   end
endmodule // temp_sensor_controller

/* design/temp_sensor_defines.vh */
// Purpose: Register offsets, field positions and reset values for the sensor controller
// Assumes: Included by its bare name from the design files
// Notes: Definitions only
`ifndef TEMP_SENSOR_DEFINES_VH
`define TEMP_SENSOR_DEFINES_VH
// Register offsets
`define SNS_CTRL_ADDR 8'h92
`define SNS_LEVEL_ADDR 8'h93
`define SNS_DIV_ADDR 8'h94
`define SNS_WAIT_ADDR 8'h95
`define SNS_RESULT_ADDR 8'h96
`define SNS_PEAK_HI_ADDR 8'h97
`define SNS_PEAK_LO_ADDR 8'h98
// Control register fields
`define CTRL_PON_BIT 7
`define CTRL_CLR_ALARM_BIT 6
`define CTRL_WIDE_BIT 5
`define CTRL_TOGGLE_BIT 4
`define CTRL_CLR_HI_BIT 3
`define CTRL_CLR_LO_BIT 2
`define CTRL_MODE_HI 1
`define CTRL_MODE_LO 0
// Result register fields
`define RES_CMP_BIT 7
`define RES_ALARM_BIT 6
// Mode encodings
`define MODE_RAW 2'h0
`define MODE_ONESHOT 2'h1
`define MODE_CONT 2'h2
`define MODE_CONT_HOLD 2'h3
// Sweep span
`define SWEEP_NARROW_START 6'h16
`define SWEEP_WIDE_START 6'h00
`define SWEEP_END 6'h3f
// Reset values
`define CTRL_RESET 8'h00
`define LEVEL_RESET 6'h00
`define DIV_RESET 8'h01
`define WAIT_RESET 8'h00
`define PEAK_HI_RESET 6'h00
`define PEAK_LO_RESET 6'h3f
`endif

/* design/sensor_clock_tick.v */
// Purpose: Divides the digital clock into one-cycle controller ticks
// Assumes: Divider value 0 or 1 gives a tick every clock
// Notes: Counter restarts when the divider value drops below it
`timescale 1ns/10ps
module sensor_clock_tick #(
   parameter WIDTH = 8
) (
   input wire ref_clk_in, // Digital clock
   input wire rst_n_in, // Synchronous reset, active low
   input wire [WIDTH-1:0] div_in, // Divider value
   output reg tick_out // One-cycle tick
);
   reg [WIDTH-1:0] count;

   // Count clocks, tick once per divider period
   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         count <= {WIDTH{1'b0}};
         tick_out <= 1'b0;
      end else if (count + {{(WIDTH-1){1'b0}}, 1'b1} >= div_in) begin
         count <= {WIDTH{1'b0}};
         tick_out <= 1'b1;
      end else begin
         count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
         tick_out <= 1'b0;
      end
   end
endmodule // sensor_clock_tick

/* bench/sensor_cmp_model.sv */
// Purpose: Comparator model of the analog temperature sensor
// Assumes: Comparator settles within the cycle the level changes
// Notes: Sense flips with invert_in to exercise both awaited edges
`timescale 1ns/10ps
module sensor_cmp_model (
   input wire [5:0] level_in, // Level from controller
   input wire [5:0] temp_in, // Simulated temperature code
   input wire invert_in, // Flip comparator sense
   output wire cmp_out // Comparator output
);
   // Trips once the level reaches the temperature
   assign cmp_out = (level_in >= temp_in) ^ invert_in;
endmodule // sensor_cmp_model

/* bench/temp_sensor_controller_chk.sv */
// Purpose: Port-level assertions for the sensor controller
// Assumes: Mode and level change only through register writes
// Notes: Bound to the controller top
`timescale 1ns/10ps
module temp_sensor_controller_chk (
   input wire ref_clk_in, // Clock
   input wire rst_n_in, // Reset
   input wire [7:0] reg_addr_in, // Address
   input wire [7:0] reg_wdata_in, // Write data
   input wire reg_wr_in, // Write strobe
   input wire reg_rd_in, // Read strobe
   input wire [7:0] reg_rdata_out, // Read data
   input wire sensor_cmp_in, // Comparator
   input wire [5:0] sensor_level_out, // Level
   input wire sensor_pon_out, // Power
   input wire busy_out // Busy
);
   reg [1:0] shadow_mode;
   reg [5:0] shadow_level;
   reg shadow_pon;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   // Shadow copies of written fields
   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         shadow_mode <= 2'h0;
         shadow_pon <= 1'b0;
         shadow_level <= 6'h00;
      end else if (reg_wr_in && reg_addr_in == 8'h92) begin
         shadow_mode <= reg_wdata_in[1:0];
         shadow_pon <= reg_wdata_in[7];
      end else if (reg_wr_in && reg_addr_in == 8'h93) begin
         shadow_level <= reg_wdata_in[5:0];
      end
   end
   sequence s_rd(a); reg_rd_in && reg_addr_in == a; endsequence
   sequence s_shot; reg_wr_in && reg_addr_in == 8'h92 && reg_wdata_in[7] && reg_wdata_in[1:0] == 2'h1; endsequence
   a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out)) else $error("read data moved");
   a_unmapped_zero: assert property (reg_rd_in && (reg_addr_in < 8'h92 || reg_addr_in > 8'h98)
      |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
   a_pon_follows: assert property (sensor_pon_out == shadow_pon) else $error("power bit wrong");
   a_raw_level: assert property (shadow_mode == 2'h0 |-> sensor_level_out == shadow_level)
      else $error("raw level not driven");
   a_level_read: assert property (s_rd(8'h93) |=> reg_rdata_out[5:0] == $past(shadow_level))
      else $error("level readback wrong");
   a_cmp_direct: assert property (s_rd(8'h96) |=> reg_rdata_out[7] == $past(sensor_cmp_in))
      else $error("comparator bit wrong");
   a_action_bits: assert property (s_rd(8'h92) |=> reg_rdata_out[6] == 1'b0 && reg_rdata_out[3:2] == 2'h0)
      else $error("action bits read back");
   a_idle_unpowered: assert property (!sensor_pon_out |=> !busy_out) else $error("busy while off");
   a_shot_starts: assert property (s_shot |-> ##[1:3] busy_out) else $error("one-shot did not start");
endmodule // temp_sensor_controller_chk
bind temp_sensor_controller temp_sensor_controller_chk temp_sensor_controller_chk_i (.ref_clk_in, .rst_n_in,
   .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .sensor_cmp_in, .sensor_level_out,
   .sensor_pon_out, .busy_out);

/* bench/temp_sensor_controller_tb.sv */
// Purpose: Self-checking bench for the temperature sensor controller
// Assumes: Comparator model stands on the sensor side
// Notes: Random one-shot sweeps mixed with fixed corners
`timescale 1ns/10ps
module temp_sensor_controller_tb;
   logic ref_clk = 0, rst_n = 0, wr = 0, rd = 0, inv = 0;
   logic [7:0] addr = 8'h00, wdat = 8'h00;
   logic [5:0] temp = 6'h01, hi = 6'h00, lo = 6'h3f;
   wire [7:0] rdat;
   wire [5:0] lvl;
   wire cmp, pon, busy;
   int bad_count = 0, samples_checked = 0, seed, n, i;
   logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h3f};
   temp_sensor_controller temp_sensor_controller_i (.ref_clk_in(ref_clk), .rst_n_in(rst_n), .reg_addr_in(addr),
      .reg_wdata_in(wdat), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .sensor_cmp_in(cmp),
      .sensor_level_out(lvl), .sensor_pon_out(pon), .busy_out(busy));
   sensor_cmp_model sensor_cmp_model_i (.level_in(lvl), .temp_in(temp), .invert_in(inv), .cmp_out(cmp));
   // Clock
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic chk(input [7:0] s, e);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("wrong value at %0t: got %h want %h", $time, s, e);
      end
   endtask
   task automatic complete_run;
      if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic wreg(input [7:0] a, d);
      @(posedge ref_clk);
      addr <= a;
      wdat <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask
   task automatic rchk(input [7:0] a, e, m = 8'hff);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      @(negedge ref_clk);
      chk(rdat & m, e);
   endtask
   // Expected sweep result
   function automatic [5:0] exp_res(input [5:0] t, input w);
      exp_res = (t > (w ? 6'h00 : 6'h16)) ? t : 6'h3f;
   endfunction
   // One-shot sweep, then result, alarm and peaks
   task automatic measure(input [5:0] t, input w, g, input [5:0] th, input [7:0] d);
      int s, e;
      logic [5:0] r;
      r = exp_res(t, w);
      s = w ? 0 : 22;
      e = (d == 0) ? 1 : d;
      @(posedge ref_clk);
      temp <= t;
      inv <= g;
      wreg(8'h94, d);
      wreg(8'h93, {2'h0, th});
      wreg(8'h92, {2'h2, w, g, 4'h1});
      for (n = 0; n < 9 && !busy; n++) @(negedge ref_clk);
      for (n = 0; n < 900 && busy; n++) @(negedge ref_clk);
      chk({7'h0, n >= (r - s) * e && n <= (r - s + 2) * e + 4}, 8'h01);
      repeat (3) @(posedge ref_clk);
      if (r > hi) hi = r;
      if (r < lo) lo = r;
      rchk(8'h96, {~g, r > th, r});
      rchk(8'h97, {2'h0, hi});
      rchk(8'h98, {2'h0, lo});
   endtask
   // Hang guard
   initial begin
      #(30000 * 50);
      bad_count++;
      complete_run;
   end
   // Main sequence
   initial begin
      seed = 66053;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (i = 0; i < 7; i++) rchk(8'(8'h92 + i), rv[i]);
      rchk(8'h99, 8'h00);
      wreg(8'h96, 8'hff);
      rchk(8'h96, 8'h00);
      wreg(8'h93, 8'h05);
      rchk(8'h96, 8'h80);
      chk({2'h0, lvl}, 8'h05);
      measure(6'h0a, 1'b1, 1'b0, 6'h00, 8'h00);
      wreg(8'h92, 8'hc0);
      rchk(8'h96, 8'h0a);
      wreg(8'h92, 8'h8c);
      rchk(8'h97, 8'h00);
      rchk(8'h98, 8'h3f);
      hi = 6'h00;
      lo = 6'h3f;
      measure(6'h10, 1'b0, 1'b1, 6'h3f, 8'h03);
      measure(6'h3f, 1'b0, 1'b0, 6'h20, 8'h02);
      repeat (8) measure(6'($random(seed)), 1'($random(seed)), 1'($random(seed)), 6'($random(seed)),
         8'({$random(seed)} % 3 + 1));
      // Continuous, then held alarm, then following alarm
      @(posedge ref_clk);
      temp <= 6'h0a;
      inv <= 1'b0;
      wreg(8'h95, 8'h05);
      wreg(8'h94, 8'h02);
      wreg(8'h93, 8'h00);
      wreg(8'h92, 8'ha2);
      // Level rests at the result for (wait + 1) ticks of 2 clocks, plus one
      for (n = 0; n < 300 && lvl != 6'h09; n++) @(negedge ref_clk);
      for (n = 0; n < 300 && lvl != 6'h0a; n++) @(negedge ref_clk);
      for (n = 0; n < 300 && lvl == 6'h0a; n++) @(negedge ref_clk);
      chk({7'h0, n >= 12 && n <= 14}, 8'h01);
      repeat (300) @(posedge ref_clk);
      rchk(8'h96, 8'h4a, 8'h7f);
      wreg(8'h92, 8'ha3);
      wreg(8'h93, 8'h3f);
      repeat (300) @(posedge ref_clk);
      rchk(8'h96, 8'h4a, 8'h7f);
      wreg(8'h92, 8'ha2);
      repeat (300) @(posedge ref_clk);
      rchk(8'h96, 8'h0a, 8'h7f);
      // Power-off in mid-run drops the running measurement
      chk({6'h0, pon, busy}, 8'h03);
      wreg(8'h92, 8'h02);
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk({6'h0, pon, busy}, 8'h00);
      complete_run;
   end
endmodule // temp_sensor_controller_tb
